// >>> rtl/ebl_loader.sv
// Boot loader top: reads a serial EEPROM image and streams it to the device.
// Function
// - After reset, if enabled, send target address; retry until the EEPROM acknowledges it.
// - Detect an answering EEPROM, then move the image in sequential reads, restarted at each page turn.
// - Header bytes 0 to 2 must match the signature, else no load.
// - Checksum over header bytes 0 to 6 is checked against byte 15.
// - Read image sequentially until a page-turn or end instruction appears.
// - Page turn: new access with slave address and new word address, no header.
// - End instruction: stop the bus access and stay idle until reset.
// - Target 7-bit address is 0x50 plus the two address pins, r/w last.
// - Header sits at 0x0, 0x800, 0x1000 or 0x1800 by target index.
// - Header read always uses two-byte word addresses; memory treated as 256-byte pages.
// - Page turn loads the upper address byte and clears the lower; slave address unchanged only with addressing-type bit 1.
// - Start address or page turn may add a 0 to 7 offset to 0x50.
// - Serial clock stays at or below 400 kHz.
// - Set boot status bit 5 when loading is done.
// - Header byte 3: bit 7 addressing type, bits 5 to 0 last page; only bit 7 is used, the last page field is ignored.
// - Eight start-address pairs at offsets 4 to 19; pins select the pair.
// - Pin value 000 selects offsets 4 and 5, 111 selects 18 and 19.
// - Addressing-type bit 1 sends a 16-bit word address, 0 sends 8 bits.
// - Header byte 20 holds the image revision; loading ignores it.
// - External request runs a single write or read transfer on the bus.
`timescale 1ns/100ps
module ebl_loader
  import ebl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Straps and control
  input  wire logic        load_en,
  input  wire logic        slave_addr_pin_lo,
  input  wire logic        slave_addr_pin_hi,
  input  wire logic        start_sel_pin,
  // Two-wire bus lines (open drain, oe low drives low)
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_q,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_q,
  // Image byte stream to the device write ports
  output logic             img_valid_q,
  output logic [7:0]       img_data_q,
  input  wire logic        img_ready,
  // Single transfer request from the serial control port
  input  wire logic        xfer_req,
  input  wire logic        xfer_rd,
  input  wire logic [6:0]  xfer_dev,
  input  wire logic [15:0] xfer_addr,
  input  wire logic [7:0]  xfer_wdata,
  output logic             xfer_done_q,
  output logic [7:0]       xfer_rdata_q,
  // Status
  output logic [7:0]       boot_status_q,
  output logic             busy_q
);
  typedef enum logic [3:0] {
    EBL_IDLE  = 4'b0000,
    EBL_START = 4'b0001,
    EBL_DEVW  = 4'b0010,
    EBL_AHI   = 4'b0011,
    EBL_ALO   = 4'b0100,
    EBL_RSTRT = 4'b0101,
    EBL_DEVR  = 4'b0110,
    EBL_RDB   = 4'b0111,
    EBL_WDB   = 4'b1000,
    EBL_STOP  = 4'b1001,
    EBL_CHECK = 4'b1010,
    EBL_OFF   = 4'b1011
  } ebl_state_t;
  typedef enum logic [1:0] {
    EBL_M_HDR  = 2'b00,
    EBL_M_IMG  = 2'b01,
    EBL_M_XFER = 2'b10
  } ebl_mode_t;

  // Two-flop synchronisers for the bus lines.
  logic [1:0] scl_s_q, sda_s_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
    end
  end

  ebl_state_t  st_q, st_d;
  ebl_mode_t   md_q, md_d;
  logic [6:0]  dev_q, dev_d;
  logic [15:0] wa_q, wa_d;
  logic [7:0]  idx_q, idx_d, sum_q, sum_d, cfg_q, cfg_d, shi_q, shi_d;
  logic [7:0]  slo_q, slo_d, pg_q, pg_d, xr_q, xr_d;
  logic        sig_ok_q, sig_ok_d, pend_q, pend_d, done_q, done_d, xd_q, xd_d;
  logic        ec_valid, ec_last, ec_done, ec_nack, e_scl, e_sda;
  ebl_cmd_t    ec_cmd;
  logic [7:0]  ec_data, ec_rd;
  logic        bf_valid, bf_ready;
  logic [7:0]  bf_data;
  logic        issue, last_rd;
  logic [1:0]  tgt;
  logic [2:0]  sel;

  assign tgt = {slave_addr_pin_hi, slave_addr_pin_lo};
  assign sel = {start_sel_pin, tgt};
  assign issue = !ec_done && !(st_q == EBL_RDB && md_q == EBL_M_IMG && !bf_ready);
  assign last_rd = (md_q == EBL_M_XFER) || (md_q == EBL_M_HDR && idx_q == EBL_HDR_LEN - 8'h01) ||
                   (md_q == EBL_M_IMG && (pend_q || done_q));

  always_comb begin
    ec_cmd  = EBL_CMD_WRITE;
    ec_data = 8'h00;
    ec_last = 1'b0;
    ec_valid = 1'b0;
    unique case (st_q)
      EBL_START, EBL_RSTRT: begin ec_cmd = EBL_CMD_START; ec_valid = issue; end
      EBL_DEVW: begin ec_data = {dev_q, 1'b0}; ec_valid = issue; end
      EBL_AHI:  begin ec_data = wa_q[15:8]; ec_valid = issue; end
      EBL_ALO:  begin ec_data = wa_q[7:0]; ec_valid = issue; end
      EBL_DEVR: begin ec_data = {dev_q, 1'b1}; ec_valid = issue; end
      EBL_WDB:  begin ec_data = xfer_wdata; ec_valid = issue; end
      EBL_RDB:  begin ec_cmd = EBL_CMD_READ; ec_last = last_rd; ec_valid = issue; end
      EBL_STOP: begin ec_cmd = EBL_CMD_STOP; ec_valid = issue; end
      default: ec_valid = 1'b0;
    endcase
  end

  always_comb begin
    st_d = st_q; md_d = md_q; dev_d = dev_q; wa_d = wa_q; idx_d = idx_q;
    sum_d = sum_q; cfg_d = cfg_q; shi_d = shi_q; slo_d = slo_q; pg_d = pg_q;
    sig_ok_d = sig_ok_q; pend_d = pend_q; done_d = done_q; xd_d = 1'b0; xr_d = xr_q;
    bf_valid = 1'b0;
    bf_data  = ec_rd;
    unique case (st_q)
      EBL_IDLE: begin
        if (load_en && !done_q) begin
          md_d = EBL_M_HDR;
          dev_d = EBL_BASE_ADDR | {5'h00, tgt};
          wa_d = EBL_HDR_STEP * {14'h0000, tgt};
          idx_d = 8'h00; sum_d = 8'h00; sig_ok_d = 1'b1;
          st_d = EBL_START;
        end else if (xfer_req) begin
          md_d = EBL_M_XFER; dev_d = xfer_dev; wa_d = xfer_addr;
          st_d = EBL_START;
        end
      end
      EBL_START: if (ec_done) st_d = EBL_DEVW;
      EBL_DEVW: begin
        if (ec_done) begin
          // A missing answer during boot retries the address phase.
          if (ec_nack && md_q != EBL_M_XFER) st_d = EBL_START;
          else if (ec_nack) st_d = EBL_STOP;
          else if (md_q == EBL_M_IMG && !cfg_q[EBL_AT_BIT]) st_d = EBL_ALO;
          else st_d = EBL_AHI;
        end
      end
      EBL_AHI: if (ec_done) st_d = ec_nack ? EBL_STOP : EBL_ALO;
      EBL_ALO: begin
        if (ec_done)
          st_d = ec_nack ? EBL_STOP : (md_q == EBL_M_XFER && !xfer_rd) ? EBL_WDB : EBL_RSTRT;
      end
      EBL_RSTRT: if (ec_done) st_d = EBL_DEVR;
      EBL_DEVR: if (ec_done) st_d = ec_nack ? EBL_STOP : EBL_RDB;
      EBL_WDB: if (ec_done) begin xd_d = 1'b1; st_d = EBL_STOP; end
      EBL_RDB: begin
        if (ec_done) begin
          idx_d = idx_q + 8'h01;
          unique case (md_q)
            EBL_M_HDR: begin
              if (idx_q <= EBL_SUM_LAST || idx_q == EBL_CSUM_OFS)
                sum_d = sum_q + ec_rd;
              if ((idx_q == EBL_SIG_OFS0 && ec_rd != EBL_SIG0) ||
                  (idx_q == 8'h01 && ec_rd != EBL_SIG1) ||
                  (idx_q == EBL_SIG_OFS2 && ec_rd != EBL_SIG2)) sig_ok_d = 1'b0;
              if (idx_q == EBL_CFG_OFS) cfg_d = ec_rd;
              if (idx_q == EBL_START_OFS + {4'h0, sel, 1'b0}) shi_d = ec_rd;
              if (idx_q == EBL_START_OFS + {4'h0, sel, 1'b1}) slo_d = ec_rd;
              // Byte 20 (revision) is read but has no effect.
              if (idx_q == EBL_HDR_LEN - 8'h01) st_d = EBL_STOP;
            end
            EBL_M_IMG: begin
              // The read after an instruction is nacked, so the EEPROM frees the data line.
              if (pend_q || done_q) begin
                pend_d = 1'b0;
                if (pend_q) pg_d = ec_rd;
                st_d   = EBL_STOP;
              end else if (ec_rd == EBL_OP_PAGE) pend_d = 1'b1;
              else if (ec_rd == EBL_OP_END) done_d = 1'b1;
              else bf_valid = 1'b1;
            end
            default: begin xr_d = ec_rd; xd_d = 1'b1; st_d = EBL_STOP; end
          endcase
        end
      end
      EBL_STOP: begin
        if (ec_done) begin
          if (md_q == EBL_M_HDR) st_d = EBL_CHECK;
          else if (md_q == EBL_M_IMG && !done_q) begin
            // Page turn: upper byte changes, device offset too with 8-bit addressing, header skipped.
            dev_d = cfg_q[EBL_AT_BIT] ? dev_q : EBL_BASE_ADDR + {4'h0, pg_q[2:0]};
            wa_d  = {pg_q, 8'h00};
            st_d  = EBL_START;
          end else st_d = (md_q == EBL_M_IMG) ? EBL_OFF : EBL_IDLE;
        end
      end
      EBL_CHECK: begin
        if (sig_ok_q && sum_q == 8'h00) begin
          md_d = EBL_M_IMG;
          dev_d = cfg_q[EBL_AT_BIT] ? dev_q : EBL_BASE_ADDR + {4'h0, shi_q[2:0]};
          wa_d = cfg_q[EBL_AT_BIT] ? {shi_q, slo_q} : {8'h00, slo_q};
          pend_d = 1'b0;
          st_d = EBL_START;
        end else begin
          done_d = 1'b1;
          st_d = EBL_OFF;
        end
      end
      EBL_OFF: begin
        // Loading stays off until reset; single transfers are still served.
        if (xfer_req) begin
          md_d = EBL_M_XFER; dev_d = xfer_dev; wa_d = xfer_addr;
          st_d = EBL_START;
        end
      end
      default: st_d = EBL_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= EBL_IDLE; md_q <= EBL_M_HDR; dev_q <= 7'h00; wa_q <= 16'h0000;
      idx_q <= 8'h00; sum_q <= 8'h00; cfg_q <= 8'h00; shi_q <= 8'h00;
      slo_q <= 8'h00; pg_q <= 8'h00; sig_ok_q <= 1'b0; pend_q <= 1'b0;
      done_q <= 1'b0; xd_q <= 1'b0; xr_q <= 8'h00;
    end else begin
      st_q <= st_d; md_q <= md_d; dev_q <= dev_d; wa_q <= wa_d;
      idx_q <= idx_d; sum_q <= sum_d; cfg_q <= cfg_d; shi_q <= shi_d;
      slo_q <= slo_d; pg_q <= pg_d; sig_ok_q <= sig_ok_d; pend_q <= pend_d;
      done_q <= done_d; xd_q <= xd_d; xr_q <= xr_d;
    end
  end

  // Bit engine runs at a quarter-bit rate at or below 400 kHz.
  ebl_byte_eng u_eng (
    .clk       (clk),
    .rst_b     (rst_b),
    .cmd_valid (ec_valid),
    .cmd       (ec_cmd),
    .cmd_data  (ec_data),
    .cmd_last  (ec_last),
    .cmd_done  (ec_done),
    .rd_data   (ec_rd),
    .nack      (ec_nack),
    .scl_in    (scl_s_q[1]),
    .sda_in    (sda_s_q[1]),
    .scl_oe    (e_scl),
    .sda_oe    (e_sda)
  );

  logic       ov_valid;
  logic [7:0] ov_data;
  ebl_skid2 u_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (bf_valid),
    .in_data   (bf_data),
    .in_ready  (bf_ready),
    .out_valid (ov_valid),
    .out_data  (ov_data),
    .out_ready (!img_valid_q || img_ready)
  );

  // Registered outputs.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_oe_q <= 1'b1; sda_oe_q <= 1'b1; img_valid_q <= 1'b0; img_data_q <= 8'h00;
      xfer_done_q <= 1'b0; xfer_rdata_q <= 8'h00; boot_status_q <= 8'h00; busy_q <= 1'b0;
    end else begin
      scl_oe_q <= e_scl;
      sda_oe_q <= e_sda;
      if (!img_valid_q || img_ready) begin
        img_valid_q <= ov_valid;
        img_data_q  <= ov_data;
      end
      xfer_done_q  <= xd_q;
      xfer_rdata_q <= xr_q;
      boot_status_q[EBL_STATUS_BIT] <= boot_status_q[EBL_STATUS_BIT] |
                                       (st_q == EBL_OFF);
      busy_q <= (st_q != EBL_IDLE && st_q != EBL_OFF);
    end
  end
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  a_status_off: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == EBL_OFF) |=> boot_status_q[EBL_STATUS_BIT]) else $error("status missing");
  a_bad_hdr_off: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == EBL_CHECK && !sig_ok_q) |=> (st_q == EBL_OFF)) else $error("bad header ran");
  a_sum_check: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == EBL_CHECK && sum_q != 8'h00) |=> (st_q == EBL_OFF)) else $error("bad sum ran");
  a_off_stays: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == EBL_OFF) |=> (st_q == EBL_OFF || md_q == EBL_M_XFER)) else $error("loader woke");
  a_nack_retry: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == EBL_DEVW && ec_done && ec_nack && md_q == EBL_M_HDR) |=> (st_q == EBL_START))
    else $error("no retry");
  a_dev_range: assert property (@(posedge clk) disable iff (!rst_b)
    (md_q != EBL_M_XFER && st_q == EBL_DEVW) |-> (dev_q[6:3] == 4'ha)) else $error("bad dev");
  a_page_upper: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == EBL_STOP && ec_done && md_q == EBL_M_IMG && !done_q) |=> (wa_q == {$past(pg_q), 8'h00}))
    else $error("page turn low byte");
  a_no_write_bad: assert property (@(posedge clk) disable iff (!rst_b)
    (md_q == EBL_M_HDR) |-> !bf_valid) else $error("header leaked");
endmodule : ebl_loader

// >>> rtl/ebl_pkg.sv
// Shared constants and types for the boot-time configuration loader.
package ebl_pkg;
  // Two-wire bus target base and header layout.
  localparam logic [6:0]  EBL_BASE_ADDR   = 7'h50;
  localparam logic [7:0]  EBL_HDR_LEN     = 8'h15;
  localparam logic [7:0]  EBL_SIG_OFS0    = 8'h00;
  localparam logic [7:0]  EBL_SIG_OFS2    = 8'h02;
  localparam logic [7:0]  EBL_SUM_LAST    = 8'h06;
  localparam logic [7:0]  EBL_CFG_OFS     = 8'h03;
  localparam logic [7:0]  EBL_CSUM_OFS    = 8'h0f;
  localparam logic [7:0]  EBL_START_OFS   = 8'h04;
  localparam int          EBL_AT_BIT      = 7;
  localparam int          EBL_STATUS_BIT  = 5;
  localparam logic [15:0] EBL_HDR_STEP    = 16'h0800;
  // Image instruction bytes; values are arbitrary.
  localparam logic [7:0]  EBL_OP_PAGE     = 8'hfe;
  localparam logic [7:0]  EBL_OP_END      = 8'hff;
  // Expected signature; values are arbitrary.
  localparam logic [7:0]  EBL_SIG0        = 8'h61;
  localparam logic [7:0]  EBL_SIG1        = 8'h62;
  localparam logic [7:0]  EBL_SIG2        = 8'h63;
  // Serial clock limit and derived quarter-bit divider.
  localparam int          EBL_CLK_HZ      = 250_000_000;
  localparam int          EBL_SCL_MAX_HZ  = 400_000;
  localparam int          EBL_QTR_CYC     = (EBL_CLK_HZ + 4 * EBL_SCL_MAX_HZ - 1)
                                            / (4 * EBL_SCL_MAX_HZ);
  // Byte engine commands.
  typedef enum logic [2:0] {
    EBL_CMD_START = 3'b000,
    EBL_CMD_WRITE = 3'b001,
    EBL_CMD_READ  = 3'b010,
    EBL_CMD_STOP  = 3'b011
  } ebl_cmd_t;
endpackage : ebl_pkg

// >>> rtl/ebl_byte_eng.sv
// Bit-level two-wire bus engine: start, byte write, byte read, stop.
`timescale 1ns/100ps
module ebl_byte_eng
  import ebl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Command
  input  wire logic       cmd_valid,
  input  wire ebl_cmd_t   cmd,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_last,
  output logic            cmd_done,
  output logic [7:0]      rd_data,
  output logic            nack,
  // Bus lines, synchronised
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_oe,
  output logic            sda_oe
);
  typedef enum logic [1:0] {
    EBL_E_IDLE = 2'b00,
    EBL_E_RUN  = 2'b01,
    EBL_E_DONE = 2'b10
  } ebl_eng_t;

  ebl_eng_t   st_q, st_d;
  logic [7:0] div_q, div_d;
  logic [5:0] ph_q, ph_d;
  logic [8:0] sh_q, sh_d;
  logic       scl_q, scl_d, sda_q, sda_d, nack_q, nack_d;
  logic       tick;
  logic [5:0] ph_end;
  logic [1:0] qp;
  logic [3:0] bitn;

  assign tick   = (div_q == 8'(EBL_QTR_CYC - 1));
  assign qp     = ph_q[1:0];
  assign bitn   = ph_q[5:2];
  assign ph_end = (cmd == EBL_CMD_START || cmd == EBL_CMD_STOP) ? 6'h03 : 6'h23;

  always_comb begin
    st_d   = st_q;
    div_d  = (st_q == EBL_E_RUN && !tick) ? div_q + 8'h01 : 8'h00;
    ph_d   = ph_q;
    sh_d   = sh_q;
    scl_d  = scl_q;
    sda_d  = sda_q;
    nack_d = nack_q;
    unique case (st_q)
      EBL_E_IDLE: begin
        if (cmd_valid) begin
          st_d = EBL_E_RUN;
          ph_d = 6'h00;
          sh_d = (cmd == EBL_CMD_READ) ? {8'hff, cmd_last} : {cmd_data, 1'b1};
        end
      end
      EBL_E_RUN: begin
        // Clock stretching: wait while the slave holds the clock low.
        if (tick && !(scl_q && !scl_in)) begin
          unique case (cmd)
            EBL_CMD_START: begin
              if (qp == 2'd0) sda_d = 1'b1;
              if (qp == 2'd1) scl_d = 1'b1;
              if (qp == 2'd2) sda_d = 1'b0;
              if (qp == 2'd3) scl_d = 1'b0;
            end
            EBL_CMD_STOP: begin
              if (qp == 2'd0) sda_d = 1'b0;
              if (qp == 2'd1) scl_d = 1'b1;
              if (qp == 2'd2) sda_d = 1'b1;
            end
            default: begin
              if (qp == 2'd0) sda_d = sh_q[8];
              if (qp == 2'd1) scl_d = 1'b1;
              if (qp == 2'd2) begin
                if (bitn == 4'd8) nack_d = sda_in;
                else sh_d = {sh_q[7:0], sda_in};
              end
              if (qp == 2'd3) scl_d = 1'b0;
            end
          endcase
          ph_d = ph_q + 6'h01;
          if (ph_q == ph_end) st_d = EBL_E_DONE;
        end
      end
      EBL_E_DONE: begin
        st_d = EBL_E_IDLE;
      end
      default: st_d = EBL_E_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q   <= EBL_E_IDLE;
      div_q  <= 8'h00;
      ph_q   <= 6'h00;
      sh_q   <= 9'h1ff;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      nack_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      div_q  <= div_d;
      ph_q   <= ph_d;
      sh_q   <= sh_d;
      scl_q  <= scl_d;
      sda_q  <= sda_d;
      nack_q <= nack_d;
    end
  end

  assign cmd_done = (st_q == EBL_E_DONE);
  assign rd_data  = sh_q[7:0];
  assign nack     = nack_q;
  assign scl_oe   = scl_q;
  assign sda_oe   = sda_q;
endmodule : ebl_byte_eng

// >>> rtl/ebl_skid2.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
module ebl_skid2
  import ebl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Fill side
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_data,
  output logic             in_ready,
  // Drain side
  output logic             out_valid,
  output logic [7:0]       out_data,
  input  wire logic        out_ready
);
  logic [7:0] mem_q [2];
  logic [7:0] mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic       rp_q, rp_d, wp_q, wp_d;
  logic       push, pop;

  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d        = ~wp_q;
    end
    if (pop) rp_d = ~rp_q;
    if (push && !pop) cnt_d = cnt_q + 2'd1;
    if (pop && !push) cnt_d = cnt_q - 2'd1;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_q <= '{8'h00, 8'h00};
      cnt_q <= 2'd0;
      rp_q  <= 1'b0;
      wp_q  <= 1'b0;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      rp_q  <= rp_d;
      wp_q  <= wp_d;
    end
  end
endmodule : ebl_skid2

// >>> test/ebl_eeprom_model.sv
// Behavioural two-wire serial EEPROM with two-byte word addressing.
`timescale 1ns/100ps
module ebl_eeprom_model #(
  parameter logic [6:0] DEV = 7'h51
) (
  // Bus lines
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_rel,
  // Test control
  input  wire logic present,
  output int        per_ns
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  sh;
  logic [15:0] wa;
  logic        act;
  logic        rd;
  logic        mack;
  int          bits;
  int          ph;
  realtime     t_up;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    sda_rel = 1'b1;
    act = 1'b0;
    mack = 1'b0;
    per_ns = 100000;
    t_up = 0;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    rd = 1'b0;
    mack = 1'b0;
    bits = 0;
    ph = 0;
  end
  always @(posedge sda) if (scl === 1'b1) act = 1'b0;
  always @(posedge scl) begin
    if (t_up > 0 && $realtime - t_up < per_ns) per_ns = int'($realtime - t_up);
    t_up = $realtime;
    if (act) begin
      if (bits < 8) sh = {sh[6:0], sda};
      else if (mack) begin
        // Master's acknowledge of a data byte this model sent.
        mack = 1'b0;
        wa = wa + 16'h0001;
        if (sda) act = 1'b0;
      end
      bits = (bits + 1) % 9;
    end
  end
  // Drive only while scl is low, so no false start or stop is made.
  always @(negedge scl) begin
    sda_rel = 1'b1;
    if (act && rd && ph > 0 && bits < 8) begin
      sda_rel = mem[wa][7 - bits];
      mack = 1'b1;
    end
    else if (act && bits == 8 && !(rd && ph > 0)) begin
      case (ph)
        0: begin
          rd = sh[0];
          act = present && sh[7:1] == DEV;
        end
        1: wa[15:8] = sh;
        2: wa[7:0] = sh;
        default: begin
          mem[wa] = sh;
          wa = wa + 16'h0001;
        end
      endcase
      ph = ph + 1;
      sda_rel = !act;
    end
  end
endmodule : ebl_eeprom_model

// >>> test/ebl_loader_tb.sv
// Self-checking bench for the boot loader against a serial EEPROM model.
`timescale 1ns/100ps
module ebl_loader_tb
  import ebl_pkg::*;
;
  localparam int LIMIT = 1_000_000;
  logic        clk = 1'b0;
  logic        rst_b, load_en, img_ready, present, xfer_req, xfer_rd;
  logic        scl_o, sda_o, scl_oe_q, sda_oe_q, img_valid_q, xfer_done_q, busy_q, sda_rel;
  logic [6:0]  xfer_dev;
  logic [7:0]  img_data_q, xfer_wdata, xfer_rdata_q, boot_status_q;
  logic [15:0] xfer_addr;
  wire         scl = scl_oe_q;
  wire         sda = sda_oe_q & sda_rel;
  int          failures, checks_done, cycles, per_ns, falls;
  logic [7:0]  got [$];
  always #2 clk = ~clk;
  ebl_loader ebl_loader_i (.clk(clk), .rst_b(rst_b), .load_en(load_en),
    .slave_addr_pin_lo(1'b1), .slave_addr_pin_hi(1'b0), .start_sel_pin(1'b0),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_q(scl_oe_q), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_q(sda_oe_q), .img_valid_q(img_valid_q), .img_data_q(img_data_q),
    .img_ready(img_ready), .xfer_req(xfer_req), .xfer_rd(xfer_rd), .xfer_dev(xfer_dev),
    .xfer_addr(xfer_addr), .xfer_wdata(xfer_wdata), .xfer_done_q(xfer_done_q),
    .xfer_rdata_q(xfer_rdata_q), .boot_status_q(boot_status_q), .busy_q(busy_q));
  ebl_eeprom_model #(.DEV(7'h51)) ebl_eeprom_model_i (.scl(scl), .sda(sda),
    .sda_rel(sda_rel), .present(present), .per_ns(per_ns));
  always @(negedge clk) if (img_valid_q === 1'b1 && img_ready) got.push_back(img_data_q);
  always @(negedge scl) falls++;
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      end_of_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic end_of_test();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // Writes a header for target index one, then resets the loader.
  task automatic boot(input logic [7:0] sig1, input logic [7:0] adj);
    logic [7:0] b [0:20];
    logic [7:0] sum;
    for (int i = 0; i < 21; i++) b[i] = 8'h00;
    b[0] = EBL_SIG0;
    b[1] = sig1;
    b[2] = EBL_SIG2;
    b[3] = 8'h91;
    b[6] = 8'h09;
    b[20] = 8'h12;
    sum = 8'h00;
    for (int i = 0; i < 7; i++) sum = sum + b[i];
    b[15] = 8'h00 - sum + adj;
    for (int i = 0; i < 21; i++) ebl_eeprom_model_i.mem[EBL_HDR_STEP + 16'(i)] = b[i];
    got.delete();
    rst_b = 1'b0;
    tick(4);
    rst_b = 1'b1;
  endtask : boot
  task automatic wait_done();
    int n = 0;
    int f;
    while (boot_status_q[EBL_STATUS_BIT] !== 1'b1 && n < 400000) begin
      tick(1);
      n++;
    end
    check(boot_status_q[EBL_STATUS_BIT], 1'b1);
    tick(2000);
    f = falls;
    load_en = 1'b0;
    tick(1);
    load_en = 1'b1;
    tick(10000);
    check({scl_o, sda_o, scl_oe_q, sda_oe_q, 12'(falls - f)}, 16'h3000);
  endtask : wait_done
  task automatic t_boot_good();
    logic [7:0] ex [3] = '{8'ha5, 8'h3c, 8'h5a};
    present = 1'b0;
    img_ready = 1'b0;
    boot(EBL_SIG1, 8'h00);
    tick(15000);
    check(boot_status_q[EBL_STATUS_BIT], 1'b0);
    present = 1'b1;
    for (int n = 0; n < 300000 && img_valid_q !== 1'b1; n++) tick(1);
    tick(3000);
    check({img_valid_q, img_data_q}, 9'h1a5);
    img_ready = 1'b1;
    wait_done();
    check(16'(got.size()), 16'd3);
    for (int i = 0; i < 3; i++) check(got[i], ex[i]);
    check(per_ns >= 2500, 1'b1);
  endtask : t_boot_good
  task automatic xfer(input logic rd, input logic [15:0] a, input logic [7:0] d);
    xfer_rd = rd;
    xfer_dev = 7'h51;
    xfer_addr = a;
    xfer_wdata = d;
    xfer_req = 1'b1;
    for (int n = 0; n < 100000 && xfer_done_q !== 1'b1; n++) tick(1);
    xfer_req = 1'b0;
    check(xfer_done_q, 1'b1);
    tick(2);
    if (rd) check(xfer_rdata_q, d);
    else check(ebl_eeprom_model_i.mem[a], d);
    for (int n = 0; n < 5000 && busy_q === 1'b1; n++) tick(1);
    check(busy_q, 1'b0);
  endtask : xfer
  task automatic t_boot_bad(input logic [7:0] sig1, input logic [7:0] adj);
    boot(sig1, adj);
    wait_done();
    check(16'(got.size()), 16'd0);
  endtask : t_boot_bad
  initial begin
    {rst_b, img_ready, present, xfer_req, xfer_rd} = '0;
    load_en = 1'b1;
    xfer_dev = 7'h00;
    xfer_addr = 16'h0000;
    xfer_wdata = 8'h00;
    tick(1);
    ebl_eeprom_model_i.mem[16'h0900] = 8'ha5;
    ebl_eeprom_model_i.mem[16'h0901] = 8'h3c;
    ebl_eeprom_model_i.mem[16'h0902] = EBL_OP_PAGE;
    ebl_eeprom_model_i.mem[16'h0903] = 8'h11;
    ebl_eeprom_model_i.mem[16'h1100] = 8'h5a;
    ebl_eeprom_model_i.mem[16'h1101] = EBL_OP_END;
    t_boot_good();
    xfer(1'b1, 16'h1100, 8'h5a);
    xfer(1'b0, 16'h2000, 8'h77);
    t_boot_bad(EBL_SIG1, 8'h01);
    t_boot_bad(EBL_SIG1 + 8'h01, 8'h00);
    end_of_test();
  end
endmodule : ebl_loader_tb
